// file: core/spi_user_map.vh
`ifndef SPI_USER_MAP_VH
`define SPI_USER_MAP_VH
`define OFF_CMD   8'h00
`define OFF_ADDR  8'h04
`define OFF_CTRL  8'h08
`define OFF_RDST  8'h10
`define OFF_TIME  8'h14
`define OFF_CLK   8'h18
`define OFF_USER  8'h1c
`define OFF_USER1 8'h20
`define OFF_USER2 8'h24
`define OFF_WLEN  8'h28
`define OFF_RLEN  8'h2c
`define OFF_WRST  8'h30
`define OFF_SLAVE 8'h38
`define OFF_BUF   2'b10
`define RST_ADDR  32'h00000000
`define RST_REG   32'h00000000
`define B_TRIG    18
`define B_WBITO   26
`define B_RBITO   25
`define B_RQIO    24
`define B_RDIO    23
`define B_WP      21
`define B_RQUAD   20
`define B_RDUAL   14
`define B_FAST    13
`define U_CMD     31
`define U_ADDR    30
`define U_DUMMY   29
`define U_RD      28
`define U_WR      27
`define U_DIDLE   26
`define U_TXHI    25
`define U_RXHI    24
`define U_SIO     16
`define U_WQIO    15
`define U_WDIO    14
`define U_WQUAD   13
`define U_WDUAL   12
`define U_WBYTE   11
`define U_RBYTE   10
`define U_OEDGE   7
`define U_IEDGE   6
`define U_SETUP   5
`define U_HOLD    4
`define U_DUPLEX  0
`define T_CSN     0
`define T_CSM     4
`define T_OUTN    8
`define T_OUTM    12
`define T_INN     16
`define T_INM     20
`define T_HOLD    24
`define T_SETUP   28
`define C_BYP     31
`define C_PRE     18
`define C_N       12
`define C_H       6
`define U1_ALEN   26
`define U1_DLEN   0
`define U2_CLEN   28
`define U2_CVAL   0
`define ST_EXT    24
`define ST_VAL    0
`define S_MODE    30
`define SLV_RDST_CMD 8'h04
`endif

// file: core/spi_user_operation_ctrl.v
// Decided for this implementation: the address-and-strobe port.
`include "spi_user_map.vh"
`default_nettype none
module spi_user_operation_ctrl #(
  parameter DLY_DEPTH = 32
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output wire [31:0] regRdata,
  output wire        busy,
  output wire        spiClkOut,
  output wire        spiClkOe,
  output wire        csOut_n,
  output wire        csOe,
  output wire [3:0]  sdOut,
  output wire [3:0]  sdOe,
  input  wire [3:0]  sdIn,
  input  wire        sclkIn,
  input  wire        csIn_n
);

  localparam TW = $clog2(DLY_DEPTH);
  localparam [9:0] S_IDLE  = 10'h001;
  localparam [9:0] S_START = 10'h002;
  localparam [9:0] S_SETUP = 10'h004;
  localparam [9:0] S_CMD   = 10'h008;
  localparam [9:0] S_ADDR  = 10'h010;
  localparam [9:0] S_DUMMY = 10'h020;
  localparam [9:0] S_WR    = 10'h040;
  localparam [9:0] S_RD    = 10'h080;
  localparam [9:0] S_HOLD  = 10'h100;
  localparam [9:0] S_DONE  = 10'h200;
  localparam [6:0] TMAX    = DLY_DEPTH[6:0] - 7'd1;

  reg        trig_q;
  reg        slave_q;
  reg [31:0] addr_q, ctrl_q, st_q, time_q, clk_q;
  reg [31:0] user_q, user1_q, user2_q, wlen_q, rlen_q, wrst_q;
  reg [31:0] buf_q [0:15];
  reg [31:0] rAddr_q, rCtrl_q, rTime_q, rClk_q, rUser_q;
  reg [31:0] rUser1_q, rUser2_q, rWlen_q, rRlen_q, rWrst_q;
  reg [31:0] rdata_q;
  reg [9:0]  state_q;
  reg [9:0]  cnt_q;
  reg [12:0] preCnt_q;
  reg [5:0]  divCnt_q;
  reg        sclk_q;
  reg        sclkOut_q;
  reg        clkEn_q;
  reg [3:0]  sdSy1_q, sdSy2_q;
  reg [1:0]  sclkSy_q, csSy_q;
  reg        sclkD_q;
  reg [5:0]  slvCnt_q;
  reg [7:0]  slvCmd_q;
  reg        slvOut_q, slvDrv_q;
  reg [DLY_DEPTH-1:0] csLine_q;
  reg [7:0]  outMem_q [0:DLY_DEPTH-1];
  reg [3:0]  inMem_q [0:DLY_DEPTH-1];
  reg        csOutN_q, csOe_q, spiClkOe_q;
  reg [3:0]  sdOut_q, sdOe_q;
  reg [9:0]  next_d, plen_d;
  reg [2:0]  w_d;
  integer    i;
  wire        rxEn;
  wire [15:0] rxIdx;
  wire [19:0] rxBit;
  wire [3:0]  rxVal;

  // run copies drive the engine so mid-run writes wait for next trigger
  wire        cmdEn   = rUser_q[`U_CMD];
  wire        addrEn  = rUser_q[`U_ADDR];
  wire        dummyEn = rUser_q[`U_DUMMY];
  wire        rdEn    = rUser_q[`U_RD];
  wire        wrEn    = rUser_q[`U_WR];
  wire        duplex  = rUser_q[`U_DUPLEX];
  wire        sio     = rUser_q[`U_SIO];
  wire        fast    = rCtrl_q[`B_FAST];
  wire [12:0] pre     = rClk_q[`C_PRE+:13];
  wire [5:0]  divN    = rClk_q[`C_N+:6];
  wire [5:0]  divH    = rClk_q[`C_H+:6];
  wire [3:0]  cmdLenM = rUser2_q[`U2_CLEN+:4];
  wire [5:0]  addrLenM = rUser1_q[`U1_ALEN+:6];
  wire        idle    = (state_q == S_IDLE);
  wire        running = ~idle & (state_q != S_START);
  wire        edgeSel = rUser_q[`U_OEDGE] | rUser_q[`U_IEDGE];

  assign busy      = ~idle;
  assign regRdata  = rdata_q;
  assign csOut_n   = csOutN_q;
  assign csOe      = csOe_q;
  assign sdOut     = sdOut_q;
  assign sdOe      = sdOe_q;
  assign spiClkOe  = spiClkOe_q;

  // register file and data buffer
  always @(posedge mclk) begin
    if (!rst_n) begin
      trig_q  <= 1'b0;
      slave_q <= 1'b0;
      addr_q  <= `RST_ADDR;
      ctrl_q  <= `RST_REG;
      st_q    <= `RST_REG;
      time_q  <= `RST_REG;
      clk_q   <= `RST_REG;
      user_q  <= `RST_REG;
      user1_q <= `RST_REG;
      user2_q <= `RST_REG;
      wlen_q  <= `RST_REG;
      rlen_q  <= `RST_REG;
      wrst_q  <= `RST_REG;
      for (i = 0; i < 16; i = i + 1)
        buf_q[i] <= `RST_REG;
    end else begin
      if (regWr && regAddr == `OFF_CMD)
        trig_q <= regWdata[`B_TRIG];
      else if (state_q == S_DONE)
        trig_q <= 1'b0;
      if (regWr) begin
        if (regAddr == `OFF_ADDR) addr_q <= regWdata;
        else if (regAddr == `OFF_CTRL) ctrl_q <= regWdata;
        else if (regAddr == `OFF_RDST) st_q <= regWdata;
        else if (regAddr == `OFF_TIME) time_q <= regWdata;
        else if (regAddr == `OFF_CLK) clk_q <= regWdata;
        else if (regAddr == `OFF_USER) user_q <= regWdata;
        else if (regAddr == `OFF_USER1) user1_q <= regWdata;
        else if (regAddr == `OFF_USER2) user2_q <= regWdata;
        else if (regAddr == `OFF_WLEN) wlen_q <= regWdata;
        else if (regAddr == `OFF_RLEN) rlen_q <= regWdata;
        else if (regAddr == `OFF_WRST) wrst_q <= regWdata;
        else if (regAddr == `OFF_SLAVE) slave_q <= regWdata[`S_MODE];
        else if (regAddr[7:6] == `OFF_BUF)
          buf_q[regAddr[5:2]] <= regWdata;
      end
      // received bits override a same-cycle bus write
      for (i = 0; i < 4; i = i + 1)
        if (rxEn && i < w_d)
          buf_q[rxIdx[i*4+:4]][rxBit[i*5+:5]] <= rxVal[i];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (regRd) begin
      if (regAddr == `OFF_CMD) rdata_q <= {13'h0000, trig_q, 18'h00000};
      else if (regAddr == `OFF_ADDR) rdata_q <= addr_q;
      else if (regAddr == `OFF_CTRL) rdata_q <= ctrl_q;
      else if (regAddr == `OFF_RDST) rdata_q <= st_q;
      else if (regAddr == `OFF_TIME) rdata_q <= time_q;
      else if (regAddr == `OFF_CLK) rdata_q <= clk_q;
      else if (regAddr == `OFF_USER) rdata_q <= user_q;
      else if (regAddr == `OFF_USER1) rdata_q <= user1_q;
      else if (regAddr == `OFF_USER2) rdata_q <= user2_q;
      else if (regAddr == `OFF_WLEN) rdata_q <= wlen_q;
      else if (regAddr == `OFF_RLEN) rdata_q <= rlen_q;
      else if (regAddr == `OFF_WRST) rdata_q <= wrst_q;
      else if (regAddr == `OFF_SLAVE)
        rdata_q <= {1'b0, slave_q, 22'h000000, slvCmd_q};
      else if (regAddr[7:6] == `OFF_BUF)
        rdata_q <= buf_q[regAddr[5:2]];
      else
        rdata_q <= 32'h00000000;
    end
  end

  // snapshot at start
  always @(posedge mclk) begin
    if (!rst_n) begin
      rAddr_q  <= `RST_ADDR;
      rCtrl_q  <= `RST_REG;
      rTime_q  <= `RST_REG;
      rClk_q   <= `RST_REG;
      rUser_q  <= `RST_REG;
      rUser1_q <= `RST_REG;
      rUser2_q <= `RST_REG;
      rWlen_q  <= `RST_REG;
      rRlen_q  <= `RST_REG;
      rWrst_q  <= `RST_REG;
    end else if (idle && trig_q && !slave_q) begin
      rAddr_q  <= addr_q;
      rCtrl_q  <= ctrl_q;
      rTime_q  <= time_q;
      rClk_q   <= clk_q;
      rUser_q  <= user_q;
      rUser1_q <= user1_q;
      rUser2_q <= user2_q;
      rWlen_q  <= wlen_q;
      rRlen_q  <= rlen_q;
      rWrst_q  <= wrst_q;
    end
  end

  // divider: low while count is at or below the high count
  wire       fullRate = rClk_q[`C_BYP] | (pre == 13'h0000 && divN == 6'h00);
  wire       preTick  = (preCnt_q == pre);
  wire [5:0] divNext  = (divCnt_q == divN) ? 6'h00 : divCnt_q + 6'h01;
  wire shiftEn  = running & (fullRate | (preTick & divCnt_q == divN));
  wire sampleEn = running & (fullRate | (preTick & divCnt_q == divH));

  always @(posedge mclk) begin
    if (!rst_n || !running) begin
      preCnt_q <= 13'h0000;
      divCnt_q <= 6'h00;
      sclk_q   <= 1'b0;
    end else if (preTick) begin
      preCnt_q <= 13'h0000;
      divCnt_q <= divNext;
      sclk_q   <= (divNext > divH);
    end else
      preCnt_q <= preCnt_q + 13'h0001;
  end

  wire sendPh = (state_q == S_CMD) | (state_q == S_ADDR) |
                (state_q == S_WR);
  wire dataPh = sendPh | (state_q == S_RD);
  wire clkOn  = dataPh |
                ((state_q == S_DUMMY) & ~rUser_q[`U_DIDLE]);

  always @(posedge mclk) begin
    if (!rst_n) begin
      clkEn_q   <= 1'b0;
      sclkOut_q <= 1'b0;
    end else begin
      clkEn_q   <= clkOn;
      sclkOut_q <= sclk_q & clkOn;
    end
  end

  // bypass hands the system clock straight out; gate is glitch prone
  assign spiClkOut = fullRate ? (clkEn_q & mclk) : sclkOut_q;

  // lane widths per phase
  wire useRd = rdEn & ~wrEn;
  wire [2:0] rdW = duplex ? 3'd1 :
    (fast & (rCtrl_q[`B_RQIO] | rCtrl_q[`B_RQUAD])) ? 3'd4 :
    (fast & (rCtrl_q[`B_RDIO] | rCtrl_q[`B_RDUAL])) ? 3'd2 : 3'd1;
  wire [2:0] wrW = duplex ? 3'd1 :
    (rUser_q[`U_WQIO] | rUser_q[`U_WQUAD]) ? 3'd4 :
    (rUser_q[`U_WDIO] | rUser_q[`U_WDUAL]) ? 3'd2 : 3'd1;
  wire [2:0] adW = duplex ? 3'd1 : useRd ?
    ((fast & rCtrl_q[`B_RQIO]) ? 3'd4 :
     (fast & rCtrl_q[`B_RDIO]) ? 3'd2 : 3'd1) :
    (rUser_q[`U_WQIO] ? 3'd4 : rUser_q[`U_WDIO] ? 3'd2 : 3'd1);

  // phase order and lengths
  wire [9:0] afterRd  = rUser_q[`U_HOLD] ? S_HOLD : S_DONE;
  wire [9:0] afterWr  = (rdEn & ~duplex) ? S_RD : afterRd;
  wire [9:0] afterDum = wrEn ? S_WR : rdEn ? S_RD : afterRd;
  wire [9:0] afterAdr = dummyEn ? S_DUMMY : afterDum;
  wire [9:0] afterCmd = addrEn ? S_ADDR : afterAdr;
  wire [9:0] afterSet = cmdEn ? S_CMD : afterCmd;
  wire [9:0] afterSt  = (rUser_q[`U_SETUP] & ~duplex) ? S_SETUP :
                        afterSet;

  always @* begin
    next_d = S_DONE;
    plen_d = 10'd1;
    w_d    = 3'd1;
    case (state_q)
      S_SETUP: begin
        next_d = afterSet;
        plen_d = {6'd0, rTime_q[`T_SETUP+:4]};
      end
      S_CMD: begin
        next_d = afterCmd;
        plen_d = {6'd0, cmdLenM} + 10'd1;
      end
      S_ADDR: begin
        next_d = afterAdr;
        plen_d = {4'd0, addrLenM} + 10'd1;
        w_d    = adW;
      end
      S_DUMMY: begin
        next_d = afterDum;
        plen_d = {2'd0, rUser1_q[`U1_DLEN+:8]} + 10'd1;
      end
      S_WR: begin
        next_d = afterWr;
        plen_d = {1'b0, rWlen_q[8:0]} + 10'd1;
        w_d    = wrW;
      end
      S_RD: begin
        next_d = afterRd;
        plen_d = {1'b0, rRlen_q[8:0]} + 10'd1;
        w_d    = rdW;
      end
      S_HOLD: begin
        next_d = S_DONE;
        plen_d = {6'd0, rTime_q[`T_HOLD+:4]};
      end
      default: begin
        next_d = S_DONE;
      end
    endcase
  end

  wire lastStep = ({1'b0, cnt_q} + {8'd0, w_d}) >= {1'b0, plen_d};

  // operation engine, one step per falling spi clock
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q   <= 10'd0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= 10'd0;
          if (trig_q && !slave_q)
            state_q <= S_START;
        end
        S_START: begin
          state_q <= afterSt;
        end
        S_DONE: begin
          state_q <= S_IDLE;
        end
        default: begin
          if (shiftEn) begin
            if (lastStep) begin
              state_q <= next_d;
              cnt_q   <= 10'd0;
            end else
              cnt_q <= cnt_q + {7'd0, w_d};
          end
        end
      endcase
    end
  end

  function [4:0] bitSel;
    input [4:0] p;
    input       lsb;
    input       big;
    begin
      bitSel = {big ? ~p[4:3] : p[4:3], lsb ? p[2:0] : ~p[2:0]};
    end
  endfunction

  function [6:0] tapCalc;
    input [3:0] num;
    input [1:0] mode;
    input       edg;
    input [5:0] n;
    reg   [6:0] half, full, extra, sum;
    begin
      full = {1'b0, n} + 7'd1;
      half = full >> 1;
      case (mode)
        2'd1: extra = edg ? half : full;
        2'd2: extra = edg ? full : half;
        2'd3: extra = full;
        default: extra = 7'd0;
      endcase
      sum = {3'd0, num} + extra;
      tapCalc = (sum > TMAX) ? TMAX : sum;
    end
  endfunction

  // half a spi clock is counted from the divide count only
  wire [6:0] csTap = tapCalc(rTime_q[`T_CSN+:4], rTime_q[`T_CSM+:2],
                             edgeSel, divN);
  wire [6:0] outTap = tapCalc(rTime_q[`T_OUTN+:4], rTime_q[`T_OUTM+:2],
                              edgeSel, divN);
  wire [6:0] inTap = tapCalc(rTime_q[`T_INN+:4], rTime_q[`T_INM+:2],
                             edgeSel, divN);

  // serial values for command and address
  wire        wLsb  = rCtrl_q[`B_WBITO];
  wire        wBig  = rUser_q[`U_WBYTE];
  wire [15:0] cval  = rUser2_q[`U2_CVAL+:16];
  wire [15:0] cmdSw = wBig ? cval : {cval[7:0], cval[15:8]};
  wire [31:0] aSw   = wBig ? rAddr_q :
    {rAddr_q[7:0], rAddr_q[15:8], rAddr_q[23:16], rAddr_q[31:24]};
  wire [63:0] aVal  = (addrLenM > 6'd31) ? {rAddr_q, rWrst_q} :
                      {32'h00000000, aSw};
  wire [3:0]  inDel;
  assign rxEn = sampleEn &
    ((state_q == S_RD) | ((state_q == S_WR) & duplex));
  wire [3:0]  rawOut, rawOe;

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_lane
      localparam [9:0] KK = k;
      wire [9:0]  pos  = cnt_q + {7'd0, w_d} - 10'd1 - KK;
      wire        act  = (KK < {7'd0, w_d});
      wire [31:0] txW  = buf_q[{rUser_q[`U_TXHI] | pos[8], pos[7:5]}];
      wire        cBit = cmdSw[wLsb ? pos[3:0] : cmdLenM - pos[3:0]];
      wire        aBit = aVal[wLsb ? pos[5:0] : addrLenM - pos[5:0]];
      wire        dBit = txW[bitSel(pos[4:0], wLsb, wBig)];
      assign rawOut[k] = (state_q == S_CMD) ? cBit :
                         (state_q == S_ADDR) ? aBit :
                         (state_q == S_WR) ? dBit :
                         (idle & (k == 2) & ctrl_q[`B_WP]);
      assign rawOe[k]  = (sendPh & act) | (idle & (k == 2));
      assign rxIdx[k*4+:4] = {rUser_q[`U_RXHI] | pos[8], pos[7:5]};
      assign rxBit[k*5+:5] = bitSel(pos[4:0], rCtrl_q[`B_RBITO],
                                    rUser_q[`U_RBYTE]);
      assign rxVal[k] = (w_d == 3'd1) ? (sio ? inDel[0] : inDel[1]) :
                        inDel[k];
    end
  endgenerate

  // delay lines, one system clock per stage
  wire csRaw = running & (state_q != S_DONE);
  wire csDel = (csTap == 7'd0) ? csRaw : csLine_q[csTap[TW-1:0] - 1'b1];
  wire [7:0] outDel = (outTap == 7'd0) ? {rawOe, rawOut} :
                      outMem_q[outTap[TW-1:0] - 1'b1];
  assign inDel = (inTap == 7'd0) ? sdSy2_q :
                 inMem_q[inTap[TW-1:0] - 1'b1];

  always @(posedge mclk) begin
    if (!rst_n) begin
      csLine_q <= {DLY_DEPTH{1'b0}};
      for (i = 0; i < DLY_DEPTH; i = i + 1) begin
        outMem_q[i] <= 8'h00;
        inMem_q[i]  <= 4'h0;
      end
    end else begin
      csLine_q <= {csLine_q[DLY_DEPTH-2:0], csRaw};
      outMem_q[0] <= {rawOe, rawOut};
      inMem_q[0]  <= sdSy2_q;
      for (i = 1; i < DLY_DEPTH; i = i + 1) begin
        outMem_q[i] <= outMem_q[i-1];
        inMem_q[i]  <= inMem_q[i-1];
      end
    end
  end

  // input synchronisers
  always @(posedge mclk) begin
    if (!rst_n) begin
      sdSy1_q  <= 4'h0;
      sdSy2_q  <= 4'h0;
      sclkSy_q <= 2'b00;
      csSy_q   <= 2'b11;
      sclkD_q  <= 1'b0;
    end else begin
      sdSy1_q  <= sdIn;
      sdSy2_q  <= sdSy1_q;
      sclkSy_q <= {sclkSy_q[0], sclkIn};
      csSy_q   <= {csSy_q[0], csIn_n};
      sclkD_q  <= sclkSy_q[1];
    end
  end

  // slave: 8 command bits, then status on falling edges msb first
  wire        sRise = sclkSy_q[1] & ~sclkD_q;
  wire        sFall = ~sclkSy_q[1] & sclkD_q;
  wire [23:0] stWord = {st_q[`ST_EXT+:8], st_q[`ST_VAL+:16]};
  wire [5:0]  sIdx = 6'd31 - slvCnt_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      slvCnt_q <= 6'd0;
      slvCmd_q <= 8'h00;
      slvOut_q <= 1'b0;
      slvDrv_q <= 1'b0;
    end else if (!slave_q || csSy_q[1]) begin
      slvCnt_q <= 6'd0;
      slvDrv_q <= 1'b0;
    end else if (sRise && slvCnt_q < 6'd8) begin
      slvCmd_q <= {slvCmd_q[6:0], sdSy2_q[0]};
      slvCnt_q <= slvCnt_q + 6'd1;
    end else if (sFall && slvCnt_q > 6'd7) begin
      if (slvCmd_q == `SLV_RDST_CMD && slvCnt_q < 6'd32) begin
        slvDrv_q <= 1'b1;
        slvOut_q <= stWord[sIdx[4:0]];
        slvCnt_q <= slvCnt_q + 6'd1;
      end else
        slvDrv_q <= 1'b0;
    end
  end

  // pin registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      csOutN_q   <= 1'b1;
      csOe_q     <= 1'b1;
      spiClkOe_q <= 1'b1;
      sdOut_q    <= 4'h0;
      sdOe_q     <= 4'h0;
    end else begin
      csOutN_q   <= ~csDel;
      csOe_q     <= ~slave_q;
      spiClkOe_q <= ~slave_q;
      sdOut_q    <= slave_q ? {2'b00, slvOut_q, 1'b0} : outDel[3:0];
      sdOe_q     <= slave_q ? {2'b00, slvDrv_q, 1'b0} : outDel[7:4];
    end
  end

endmodule // spi_user_operation_ctrl
`default_nettype wire

// file: bench/spi_slave_model.sv
`default_nettype none
module spi_slave_model (
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic [3:0] dOut,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [15:0]     rxBits,
  output logic [7:0]      cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int         frame = 0;
  int         riseSeen = 0;
  int         fallSeen = 0;
  logic [2:0] k = 3'h0;
  logic       lastQ = 1'b0;
  always @(negedge csN) frame++;
  // counters restart on the first clock of each frame
  always @(posedge sclk) if (!csN) begin
    if (riseSeen != frame) begin
      riseSeen = frame;
      rxBits = 16'h0;
      cnt = 8'h0;
    end
    rxBits = {rxBits[14:0], dOut[0]};
    cnt = cnt + 8'h1;
  end
  // read bits move on falling edges, msb first
  always @(negedge sclk) if (!csN) begin
    if (fallSeen != frame) begin
      fallSeen = frame;
      k = 3'h0;
    end
    k = k + 3'h1;
  end
  always @(posedge csN) lastQ <= txByte[3'h7 - k];
  // released line shows the inverse, not a held value
  assign miso = csN ? ~lastQ
              : txByte[3'h7 - ((fallSeen == frame) ? k : 3'h0)];
endmodule // spi_slave_model
`default_nettype wire

// file: bench/spi_user_operation_ctrl_properties.sv
`default_nettype none
module spi_user_operation_ctrl_properties #(
  parameter DLY_DEPTH = 32
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic        busy,
  input wire logic        spiClkOut,
  input wire logic        spiClkOe,
  input wire logic        csOut_n,
  input wire logic        csOe,
  input wire logic [3:0]  sdOut,
  input wire logic [3:0]  sdOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] addrQ;
  logic        wpQ;
  logic        slaveQ;
  always @(posedge mclk) begin
    if (!rst_n) begin
      addrQ <= 32'h0;
      wpQ <= 1'b0;
      slaveQ <= 1'b0;
    end else if (regWr) begin
      if (regAddr == 8'h04) addrQ <= regWdata;
      if (regAddr == 8'h08) wpQ <= regWdata[21];
      if (regAddr == 8'h38) slaveQ <= regWdata[30];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence trigReq;
    regWr && regAddr == 8'h00 && regWdata[18] && !busy && !slaveQ;
  endsequence
  // four idle edges leave room for the pin flops to catch up
  sequence quiet;
    (!busy && !slaveQ && $stable(wpQ))[*4];
  endsequence
  AST_TRIG_BUSY: assert property (trigReq |-> ##[1:3] busy)
    else $error("busy did not follow trigger");
  AST_TRIG_CS: assert property (trigReq |-> ##[1:40] !csOut_n)
    else $error("chip select not asserted after trigger");
  AST_CS_IDLE: assert property (quiet |-> csOut_n)
    else $error("chip select active while idle");
  AST_WP_IDLE: assert property (
    quiet |-> sdOe[2] && sdOut[2] == wpQ)
    else $error("write protect pin wrong while idle");
  AST_CLK_IDLE: assert property (quiet |-> !spiClkOut)
    else $error("spi clock toggling while idle");
  AST_RD_ADDR: assert property (
    $past(regRd) && $past(regAddr) == 8'h04 |-> regRdata == $past(addrQ))
    else $error("address register readback wrong");
  AST_UNMAPPED: assert property (
    $past(regRd) && $past(regAddr) == 8'h3c |-> regRdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SLV_OE: assert property (
    slaveQ && $past(slaveQ, 2) |-> !spiClkOe && !csOe)
    else $error("master outputs driven in slave mode");
  AST_MST_OE: assert property (
    !slaveQ && !$past(slaveQ, 2) |-> spiClkOe && csOe)
    else $error("master outputs released in master mode");
endmodule // spi_user_operation_ctrl_properties
bind spi_user_operation_ctrl spi_user_operation_ctrl_properties #(
  .DLY_DEPTH(DLY_DEPTH)
) props (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .busy, .spiClkOut, .spiClkOe, .csOut_n, .csOe, .sdOut, .sdOe);
`default_nettype wire

// file: bench/test_spi_user_operation_ctrl.sv
`default_nettype none
module test_spi_user_operation_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        sclkIn = 1'b0;
  logic        csIn_n = 1'b1;
  logic        sIn = 1'b0;
  int          badCount = 0;
  int          checksDone = 0;
  wire [31:0]  regRdata;
  wire         busy, spiClkOut, spiClkOe, csOut_n, csOe, miso;
  wire [3:0]   sdOut, sdOe;
  wire [15:0]  rxBits;
  wire [7:0]   cnt;
  wire [3:0]   sdIn = {2'b00, miso, sIn};
  spi_user_operation_ctrl uut (.mclk, .rst_n, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .busy, .spiClkOut, .spiClkOe, .csOut_n, .csOe,
    .sdOut, .sdOe, .sdIn, .sclkIn, .csIn_n);
  spi_slave_model slv (.sclk(spiClkOut), .csN(csOut_n), .dOut(sdOut),
    .txByte(8'hc6), .miso, .rxBits, .cnt);
  initial forever #20 mclk = ~mclk;
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checksDone++;
    if (s !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic go;
    logic [31:0] v;
    wr(8'h00, 32'h00040000);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      if (i > 4 && busy === 1'b0) break;
    end
    chk("operation finished", 32'h0, {31'h0, busy});
    rd(8'h00, v);
    chk("trigger bit", 32'h0, {31'h0, v[18]});
  endtask
  task automatic tRegs;
    logic [31:0] v;
    rd(8'h04, v);
    chk("address reset", 32'h0, v);
    wr(8'h04, 32'h13572468);
    rd(8'h04, v);
    chk("address", 32'h13572468, v);
    rd(8'h3c, v);
    chk("unmapped", 32'h0, v);
    wr(8'h18, 32'h00009109);
    rd(8'h18, v);
    chk("clock reg", 32'h00009109, v);
    $display("regs test done");
  endtask
  task automatic tWp;
    for (int i = 0; i < 2; i++) begin
      wr(8'h08, i ? 32'h0 : 32'h00200000);
      repeat (4) @(posedge mclk);
      chk("wp pin", i ? 32'h0 : 32'h1, {31'h0, sdOut[2]});
    end
    $display("wp test done");
  endtask
  task automatic tCmd;
    logic [31:0] ct [3] = '{32'h0, 32'h04000000, 32'h0};
    logic [31:0] u2 [3] = '{32'h7000001b, 32'h7000001b, 32'h3000000b};
    logic [7:0]  ex [3] = '{8'h1b, 8'hd8, 8'h0b};
    logic [7:0]  nb [3] = '{8'h08, 8'h08, 8'h04};
    wr(8'h1c, 32'h80000800);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, ct[i]);
      wr(8'h24, u2[i]);
      go;
      chk("cmd bits", {24'h0, ex[i]}, {16'h0, rxBits});
      chk("cmd count", {24'h0, nb[i]}, {24'h0, cnt});
    end
    $display("command test done");
  endtask
  task automatic tWrite;
    logic [31:0] u [3] = '{32'h08000800, 32'h08000000, 32'h0a000000};
    logic [7:0]  ex [3] = '{8'h5a, 8'hc3, 8'h96};
    wr(8'h08, 32'h0);
    wr(8'h80, 32'h5a0000c3);
    wr(8'ha0, 32'h00000096);
    wr(8'h28, 32'h00000007);
    for (int i = 0; i < 3; i++) begin
      wr(8'h1c, u[i]);
      go;
      chk("write bits", {24'h0, ex[i]}, {16'h0, rxBits});
      chk("write count", 32'h8, {24'h0, cnt});
    end
    $display("write test done");
  endtask
  task automatic tRead;
    logic [31:0] v;
    logic [31:0] ct [3] = '{32'h0, 32'h01000000, 32'h00006000};
    logic [31:0] ex [3] = '{32'h000000c6, 32'h000000c6, 32'h000000a0};
    wr(8'h2c, 32'h00000007);
    wr(8'h80, 32'h0);
    wr(8'ha0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      // quad-io without fast-read must stay on one lane
      // fast dual-out: model drives lane 1 only, lane 0 reads zero
      wr(8'h08, ct[i]);
      wr(8'h1c, (i == 1) ? 32'h11000000 : 32'h10000000);
      go;
      rd((i == 1) ? 8'ha0 : 8'h80, v);
      chk("read word", ex[i], v);
    end
    $display("read test done");
  endtask
  task automatic tSlave;
    logic [23:0] got;
    logic [31:0] pat;
    got = 24'h0;
    pat = 32'h04000000;
    wr(8'h10, 32'h5c001234);
    wr(8'h38, 32'h40000000);
    @(posedge mclk);
    csIn_n <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      sIn <= pat[31 - i];
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      if (i > 7) got = {got[22:0], sdOut[1]};
      @(posedge mclk);
      sclkIn <= 1'b1;
      repeat (8) @(posedge mclk);
      sclkIn <= 1'b0;
    end
    csIn_n <= 1'b1;
    chk("slave status", 32'h005c1234, {8'h0, got});
    wr(8'h38, 32'h0);
    $display("slave test done");
  endtask
  task automatic endSim;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    tRegs;
    tWp;
    tCmd;
    tWrite;
    tRead;
    tSlave;
    endSim;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    endSim;
  end
endmodule // test_spi_user_operation_ctrl
`default_nettype wire
